// ---- ebt_pkg.sv ----
`default_nettype none
package ebt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL    = 6'h00;
    localparam logic [5:0] IDX_SHARED     = 6'h01;
    localparam logic [5:0] IDX_LOW_CAPT   = 6'h02;
    localparam logic [5:0] IDX_HIGH_CAPT  = 6'h03;
    localparam logic [5:0] IDX_LOW_HOLD   = 6'h04;
    localparam logic [5:0] IDX_HIGH_HOLD  = 6'h05;
    // Control register fields
    localparam int unsigned CTL_RUN       = 7;
    localparam int unsigned CTL_SINGLE    = 6;
    localparam int unsigned CTL_TIMEOUT   = 5;
    localparam int unsigned CTL_CLK_HI    = 4;
    localparam int unsigned CTL_CLK_LO    = 3;
    localparam int unsigned CTL_CAP_MASK  = 2;
    localparam int unsigned CTL_TO_MASK   = 1;
    localparam int unsigned CTL_ROUTE     = 0;
    // Shared register fields
    localparam int unsigned SHR_MODE      = 7;
    localparam int unsigned SHR_SEL       = 6;
    localparam int unsigned SHR_FN_HI     = 5;
    localparam int unsigned SHR_FN_LO     = 4;
    localparam int unsigned SHR_RISE_FLAG = 1;
    localparam int unsigned SHR_FALL_FLAG = 0;
    // Reset values
    localparam logic [7:0] CONTROL_RST    = 8'h00;
    localparam logic [7:0] SHARED_RST     = 8'h00;
    localparam logic [7:0] HOLD_RST       = 8'h00;
    localparam logic [7:0] CAPT_RST       = 8'h00;
    // Counter constants
    localparam logic [7:0] COUNT_FULL     = 8'hFF;
    localparam logic [7:0] COUNT_ONE      = 8'h01;
    // Clock select codes
    localparam logic [1:0] CLK_DIV1       = 2'h0;
    localparam logic [1:0] CLK_DIV2       = 2'h1;
    localparam logic [1:0] CLK_DIV4       = 2'h2;
    localparam logic [1:0] CLK_DIV8       = 2'h3;
    // Combine and edge field codes
    localparam logic [1:0] FN_AND_FALL    = 2'h0;
    localparam logic [1:0] FN_OR_RISE     = 2'h1;
    localparam logic [1:0] FN_NOR_BOTH    = 2'h2;
    localparam logic [1:0] FN_NAND_RSV    = 2'h3;
endpackage : ebt_pkg
`default_nettype wire

// ---- ebt_timer.sv ----
// Functional notes
// R1: Counter runs only while run bit is 1
// R2: Modulo-N reloads at terminal count; single-pass stops
// R3: Timeout flag set at terminal; write-1 clears
// R4: Clock select divides by 1, 2, 4, 8
// R5: Capture mask gates capture interrupt request
// R6: Timeout mask gates timeout interrupt request
// R7: Route bit puts timer output on pin
// R8: Shared mode bit: transmit or demodulation
// R9: Shared bit 6: output enable or input select
// R10: Shared bits 5:4: logic function or edge select
// R11: Rising edge to low slot, falling high
// R12: Capture sets edge flag, may interrupt
// R13: Capture reloads counter with FF, keeps counting
// R14: Zero in demod sets timeout, continues FF
// R15: Readable writable high-level hold register
// R16: Readable writable low-level hold register
// R17: First count interval after enable may be short
// R18: Software clears timeout before enabling counter
// R19: Software avoids read-modify-write on flags
// R20: Requests go out on fifth interrupt line
// R21: Decrement per tick; terminal is reaching zero
`timescale 1ns/1ns
`default_nettype none
module ebt_timer (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [7:0]  avm_address,
    input  wire logic        avm_read,
    input  wire logic        avm_write,
    input  wire logic [31:0] avm_writedata,
    input  wire logic [3:0]  avm_byteenable,
    output logic      [31:0] avm_readdata,
    output logic             avm_waitrequest,
    input  wire logic        demod_input_pin_a,
    input  wire logic        demod_input_pin_b,
    input  wire logic        sixteen_bit_timer_out,
    input  wire logic        port_out_timer_pin,
    input  wire logic        port_out_shared_pin,
    output logic             timer_output_pin,
    output logic             shared_output_pin,
    output logic             fifth_interrupt_line
);
    logic [7:0]  ctrl_r;
    logic        to_flag_r;
    logic [7:0]  shr_r;
    logic        rise_flag_r;
    logic        fall_flag_r;
    logic [7:0]  low_hold_r;
    logic [7:0]  high_hold_r;
    logic [7:0]  low_capt_r;
    logic [7:0]  high_capt_r;
    logic [7:0]  count_r;
    logic        out_r;
    logic        run_prev_r;
    logic [2:0]  presc_r;
    logic [2:0]  sync_a_r;
    logic [2:0]  sync_b_r;
    logic        ack_r;
    logic [31:0] rdata_r;
    logic        irq_r;
    logic        req;
    logic        wr_fire;
    logic [5:0]  idx;
    logic        idx_ok;
    logic        wr_ctrl;
    logic        wr_shr;
    logic        demod;
    logic        run;
    logic        tick_sel;
    logic        tick;
    logic        terminal;
    logic        to_evt;
    logic        s_new;
    logic        s_old;
    logic        edge_rise;
    logic        edge_fall;
    logic        cap_rise;
    logic        cap_fall;
    logic        cap_evt;
    logic        single_stop;

    // Checks that a byte address is word aligned and in range, flags unmapped ones
    function automatic logic addr_valid(input logic [7:0] a);
        addr_valid = (a[1:0] == 2'h0) && (a[7:2] <= ebt_pkg::IDX_HIGH_HOLD);
    endfunction : addr_valid

    // Divider tap for the selected counter clock
    function automatic logic div_tick(input logic [1:0] sel, input logic [2:0] p);
        unique case (sel)
            ebt_pkg::CLK_DIV1: div_tick = 1'b1;
            ebt_pkg::CLK_DIV2: div_tick = p[0];
            ebt_pkg::CLK_DIV4: div_tick = &p[1:0];
            ebt_pkg::CLK_DIV8: div_tick = &p;
        endcase
    endfunction : div_tick

    // Combines the two timer outputs in transmit mode
    function automatic logic combine(input logic [1:0] fn, input logic a, input logic b);
        unique case (fn)
            ebt_pkg::FN_AND_FALL: combine = a & b;
            ebt_pkg::FN_OR_RISE:  combine = a | b;
            ebt_pkg::FN_NOR_BOTH: combine = ~(a | b);
            ebt_pkg::FN_NAND_RSV: combine = ~(a & b);
        endcase
    endfunction : combine

    // Bus slave: one wait state, then the answer
    assign req             = avm_read | avm_write;
    assign avm_waitrequest = req & ~(ack_r & clk_en);
    assign avm_readdata    = rdata_r;
    assign idx             = avm_address[7:2];
    assign idx_ok          = addr_valid(avm_address);
    assign wr_fire         = avm_write & ack_r & clk_en & avm_byteenable[0] & idx_ok;
    assign wr_ctrl         = wr_fire && (idx == ebt_pkg::IDX_CONTROL);
    assign wr_shr          = wr_fire && (idx == ebt_pkg::IDX_SHARED);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else if (clk_en) begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_en && avm_read && !ack_r) begin
            rdata_r <= 32'h0000_0000;
            if (idx_ok) begin
                unique case (idx)
                    ebt_pkg::IDX_CONTROL:   rdata_r[7:0] <= {ctrl_r[7:6], to_flag_r, ctrl_r[4:0]};
                    ebt_pkg::IDX_SHARED:    rdata_r[7:0] <= {shr_r[7:4], 2'h0, rise_flag_r, fall_flag_r};
                    ebt_pkg::IDX_LOW_CAPT:  rdata_r[7:0] <= low_capt_r;
                    ebt_pkg::IDX_HIGH_CAPT: rdata_r[7:0] <= high_capt_r;
                    ebt_pkg::IDX_LOW_HOLD:  rdata_r[7:0] <= low_hold_r;
                    ebt_pkg::IDX_HIGH_HOLD: rdata_r[7:0] <= high_hold_r;
                    default:                rdata_r[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // Mode and run decode
    assign demod    = shr_r[ebt_pkg::SHR_MODE]; // R8
    assign run      = ctrl_r[ebt_pkg::CTL_RUN];
    assign tick_sel = div_tick(ctrl_r[ebt_pkg::CTL_CLK_HI:ebt_pkg::CTL_CLK_LO], presc_r); // R4
    assign tick     = clk_en & run & run_prev_r & tick_sel; // R1 R17
    assign terminal = (count_r <= ebt_pkg::COUNT_ONE) & ~(demod & ~|count_r);
    assign to_evt   = tick & terminal & ~cap_evt; // R21 R14
    assign single_stop = to_evt & ~demod & ctrl_r[ebt_pkg::CTL_SINGLE];

    // Control register; in transmit mode single pass clears the run bit at terminal count
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_r <= ebt_pkg::CONTROL_RST;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_r <= avm_writedata[7:0];
            end else if (single_stop) begin
                ctrl_r[ebt_pkg::CTL_RUN] <= 1'b0; // R2
            end
        end
    end

    // Timeout flag: hardware set wins over a write-1 clear
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            to_flag_r <= 1'b0;
        end else if (clk_en) begin
            if (to_evt) begin
                to_flag_r <= 1'b1; // R3 R14
            end else if (wr_ctrl && avm_writedata[ebt_pkg::CTL_TIMEOUT]) begin
                to_flag_r <= 1'b0; // R3
            end
        end
    end

    // Shared register and edge flags
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            shr_r       <= ebt_pkg::SHARED_RST;
            rise_flag_r <= 1'b0;
            fall_flag_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_shr) begin
                shr_r <= {avm_writedata[7:4], 4'h0}; // R9 R10
            end
            if (cap_rise) begin
                rise_flag_r <= 1'b1; // R12
            end else if (wr_shr && avm_writedata[ebt_pkg::SHR_RISE_FLAG]) begin
                rise_flag_r <= 1'b0;
            end
            if (cap_fall) begin
                fall_flag_r <= 1'b1; // R12
            end else if (wr_shr && avm_writedata[ebt_pkg::SHR_FALL_FLAG]) begin
                fall_flag_r <= 1'b0;
            end
        end
    end

    // Hold registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            low_hold_r  <= ebt_pkg::HOLD_RST;
            high_hold_r <= ebt_pkg::HOLD_RST;
        end else if (wr_fire) begin
            if (idx == ebt_pkg::IDX_LOW_HOLD) begin
                low_hold_r <= avm_writedata[7:0]; // R16
            end
            if (idx == ebt_pkg::IDX_HIGH_HOLD) begin
                high_hold_r <= avm_writedata[7:0]; // R15
            end
        end
    end

    // Free-running prescaler; the first tick after enabling may come early
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            presc_r <= 3'h0;
        end else if (clk_en) begin
            presc_r <= presc_r + 3'h1; // R17
        end
    end

    // Input synchronisers; a change counts while stage two holds the new level and stage three the old one
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync_a_r <= 3'h0;
            sync_b_r <= 3'h0;
        end else if (clk_en) begin
            sync_a_r <= {sync_a_r[1:0], demod_input_pin_a};
            sync_b_r <= {sync_b_r[1:0], demod_input_pin_b};
        end
    end

    assign s_new     = shr_r[ebt_pkg::SHR_SEL] ? sync_b_r[1] : sync_a_r[1]; // R9
    assign s_old     = shr_r[ebt_pkg::SHR_SEL] ? sync_b_r[2] : sync_a_r[2];
    assign edge_rise = s_new & ~s_old;
    assign edge_fall = ~s_new & s_old;
    always_comb begin
        cap_rise = 1'b0;
        cap_fall = 1'b0;
        if (clk_en && demod && run && run_prev_r) begin
            unique case (shr_r[ebt_pkg::SHR_FN_HI:ebt_pkg::SHR_FN_LO]) // R10
                ebt_pkg::FN_AND_FALL: cap_fall = edge_fall;
                ebt_pkg::FN_OR_RISE:  cap_rise = edge_rise;
                ebt_pkg::FN_NOR_BOTH: begin
                    cap_rise = edge_rise;
                    cap_fall = edge_fall;
                end
                ebt_pkg::FN_NAND_RSV: begin
                    cap_rise = 1'b0;
                    cap_fall = 1'b0;
                end
            endcase
        end
    end
    assign cap_evt = cap_rise | cap_fall;

    // Capture slots
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            low_capt_r  <= ebt_pkg::CAPT_RST;
            high_capt_r <= ebt_pkg::CAPT_RST;
        end else if (clk_en) begin
            if (cap_rise) begin
                low_capt_r <= count_r; // R11
            end
            if (cap_fall) begin
                high_capt_r <= count_r; // R11
            end
        end
    end

    // Counter and timer output
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            count_r    <= 8'h00;
            out_r      <= 1'b0;
            run_prev_r <= 1'b0;
        end else if (clk_en) begin
            run_prev_r <= run;
            if (run && !run_prev_r) begin
                count_r <= demod ? ebt_pkg::COUNT_FULL : low_hold_r;
                out_r   <= 1'b0;
            end else if (cap_evt) begin
                count_r <= ebt_pkg::COUNT_FULL; // R13
            end else if (tick) begin
                if (demod) begin
                    count_r <= count_r - 8'h01; // R14 R21
                end else if (terminal) begin
                    if (ctrl_r[ebt_pkg::CTL_SINGLE]) begin
                        count_r <= 8'h00; // R2
                    end else begin
                        count_r <= out_r ? low_hold_r : high_hold_r; // R2
                        out_r   <= ~out_r;
                    end
                end else begin
                    count_r <= count_r - 8'h01; // R21
                end
            end
        end
    end

    // Interrupt request pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
        end else if (clk_en) begin
            irq_r <= (to_evt & ctrl_r[ebt_pkg::CTL_TO_MASK]) // R6
                   | (cap_evt & ctrl_r[ebt_pkg::CTL_CAP_MASK]); // R5 R12
        end
    end
    assign fifth_interrupt_line = irq_r; // R20

    // Pin routing
    assign timer_output_pin  = ctrl_r[ebt_pkg::CTL_ROUTE] ? out_r : port_out_timer_pin; // R7
    assign shared_output_pin = (!demod && shr_r[ebt_pkg::SHR_SEL])
                             ? combine(shr_r[ebt_pkg::SHR_FN_HI:ebt_pkg::SHR_FN_LO], out_r, sixteen_bit_timer_out)
                             : port_out_shared_pin; // R9 R10

    // Checks
    a_stop_when_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
        (clk_en && !run) |=> $stable(count_r))
        else $error("Counter moved while stopped");
    a_modulo_reload: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
        (to_evt && !demod && !ctrl_r[ebt_pkg::CTL_SINGLE])
        |=> (count_r == ($past(out_r) ? $past(low_hold_r) : $past(high_hold_r))) && (out_r != $past(out_r)))
        else $error("Modulo reload wrong");
    a_single_stops: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
        (single_stop && !wr_ctrl) |=> !run ##1 $stable(count_r))
        else $error("Single pass did not stop");
    a_timeout_sets: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        to_evt |=> to_flag_r)
        else $error("Timeout flag not set");
    a_flag_holds: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        (to_flag_r && !(wr_ctrl && avm_writedata[ebt_pkg::CTL_TIMEOUT])) |=> to_flag_r)
        else $error("Timeout flag lost without write of one");
    a_div_spacing: assert property (@(posedge ref_clk) disable iff (!rst_b || !clk_en) // R4
        (tick_sel && ctrl_r[ebt_pkg::CTL_CLK_HI:ebt_pkg::CTL_CLK_LO] == ebt_pkg::CLK_DIV8)
        |=> (!tick_sel || ctrl_r[ebt_pkg::CTL_CLK_HI:ebt_pkg::CTL_CLK_LO] != ebt_pkg::CLK_DIV8)[*7])
        else $error("Divide by eight spacing wrong");
    a_capture_low: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
        cap_rise |=> (low_capt_r == $past(count_r)) && rise_flag_r && (count_r == ebt_pkg::COUNT_FULL))
        else $error("Rising capture wrong");
    a_capture_high: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
        cap_fall |=> (high_capt_r == $past(count_r)) && fall_flag_r && (count_r == ebt_pkg::COUNT_FULL))
        else $error("Falling capture wrong");
    a_irq_timeout: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        (to_evt && ctrl_r[ebt_pkg::CTL_TO_MASK]) |=> fifth_interrupt_line)
        else $error("Timeout interrupt missing");
    a_irq_cause: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
        $rose(fifth_interrupt_line) |-> $past((to_evt && ctrl_r[ebt_pkg::CTL_TO_MASK])
                                           || (cap_evt && ctrl_r[ebt_pkg::CTL_CAP_MASK])))
        else $error("Interrupt without enabled cause");
    a_demod_wrap: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
        (to_evt && demod) |=> (count_r == 8'h00) ##1 (!$past(tick) || count_r == ebt_pkg::COUNT_FULL))
        else $error("Demod did not continue from FF");

    c_modulo_timeout: cover property (@(posedge ref_clk) disable iff (!rst_b)
        to_evt && !demod && !ctrl_r[ebt_pkg::CTL_SINGLE]);
    c_single_stop: cover property (@(posedge ref_clk) disable iff (!rst_b) single_stop);
    c_capture_both: cover property (@(posedge ref_clk) disable iff (!rst_b)
        cap_rise ##[1:200] cap_fall);
    c_irq_capture: cover property (@(posedge ref_clk) disable iff (!rst_b)
        cap_evt && ctrl_r[ebt_pkg::CTL_CAP_MASK]);
endmodule : ebt_timer
`default_nettype wire

// ---- ebt_pin_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module ebt_pin_model (
    input  wire logic ref_clk,
    output logic      demod_input_pin_a,
    output logic      demod_input_pin_b,
    output logic      sixteen_bit_timer_out,
    output logic      port_out_timer_pin,
    output logic      port_out_shared_pin
);
    initial begin
        demod_input_pin_a     = 1'b0;
        demod_input_pin_b     = 1'b0;
        sixteen_bit_timer_out = 1'b0;
        port_out_timer_pin    = 1'b0;
        port_out_shared_pin   = 1'b0;
    end

    // Pins change just after a rising edge, like a clocked source
    task automatic set_pin(input int id, input logic v);
        @(posedge ref_clk);
        case (id)
            0: demod_input_pin_a <= v;
            1: demod_input_pin_b <= v;
            2: sixteen_bit_timer_out <= v;
            3: port_out_timer_pin <= v;
            default: port_out_shared_pin <= v;
        endcase
    endtask : set_pin
endmodule : ebt_pin_model
`default_nettype wire

// ---- tb_eight_bit_timer_demod.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_eight_bit_timer_demod;
    logic        ref_clk;
    logic        rst_b;
    logic [7:0]  avm_address;
    logic        avm_read;
    logic        avm_write;
    logic [31:0] avm_writedata;
    logic [3:0]  avm_byteenable;
    logic [31:0] avm_readdata;
    logic        avm_waitrequest;
    logic        pin_a, pin_b;
    logic        t16_out;
    logic        port_tp, port_sp;
    logic        timer_pin, shared_pin;
    logic        irq;
    logic [7:0]  rd;
    int          errors;
    int          samples_checked;
    int          cyc;
    int          irq_count;
    int          irq_last, irq_prev;
    int          base, t;

    ebt_timer u_ebt_timer (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .avm_address(avm_address),
        .avm_read(avm_read), .avm_write(avm_write), .avm_writedata(avm_writedata),
        .avm_byteenable(avm_byteenable), .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
        .demod_input_pin_a(pin_a), .demod_input_pin_b(pin_b), .sixteen_bit_timer_out(t16_out),
        .port_out_timer_pin(port_tp), .port_out_shared_pin(port_sp), .timer_output_pin(timer_pin),
        .shared_output_pin(shared_pin), .fifth_interrupt_line(irq));
    ebt_pin_model u_ebt_pin_model (.ref_clk(ref_clk), .demod_input_pin_a(pin_a), .demod_input_pin_b(pin_b),
        .sixteen_bit_timer_out(t16_out), .port_out_timer_pin(port_tp), .port_out_shared_pin(port_sp));

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // Cycle count and interrupt pulse log
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) begin
            irq_count <= irq_count + 1;
            irq_prev  <= irq_last;
            irq_last  <= cyc;
        end
    end

    task automatic end_sim;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk_int(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            errors++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk_int

    task automatic chk_rng(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
        samples_checked++;
        if (^got === 1'bx || got < lo || got > hi) begin
            errors++;
            $display("mismatch %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask : chk_rng

    // One Avalon transfer: held until waitrequest is sampled low
    task automatic bus_xfer(input logic wr, input logic [5:0] idx, input logic [7:0] d, input logic be0);
        int n;
        n = 0;
        avm_address    <= {idx, 2'h0};
        avm_writedata  <= {24'h000000, d};
        avm_byteenable <= {3'h0, be0};
        avm_write      <= wr;
        avm_read       <= ~wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avm_waitrequest !== 1'b0 && n < 20);
        if (avm_waitrequest !== 1'b0) begin
            errors++;
            $display("mismatch waitrequest expected 0 seen 1");
        end
        rd = avm_readdata[7:0];
        if (!wr) chk8("readdata upper", 8'h00, {7'h00, |avm_readdata[31:8]});
        avm_write <= 1'b0;
        avm_read  <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_xfer

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus_xfer(1'b1, idx, d, 1'b1);
    endtask : wr

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp, input string what);
        bus_xfer(1'b0, idx, 8'h00, 1'b1);
        chk8(what, exp, rd);
    endtask : rdchk

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    task automatic wait_irq(input int limit);
        int b;
        int n;
        b = irq_count;
        n = 0;
        while (irq_count == b && n < limit) begin
            @(posedge ref_clk);
            n++;
        end
        if (irq_count == b) begin
            errors++;
            $display("mismatch interrupt expected pulse seen none");
        end
    endtask : wait_irq

    function automatic logic fn_out(input int fn, input logic a, input logic b);
        case (fn)
            0: return a & b;
            1: return a | b;
            2: return ~(a | b);
            default: return ~(a & b);
        endcase
    endfunction : fn_out

    initial begin
        #400000;
        errors++;
        $display("mismatch watchdog expected finish seen timeout");
        end_sim();
    end

    initial begin
        errors = 0;
        samples_checked = 0;
        cyc = 0;
        irq_count = 0;
        irq_last = 0;
        irq_prev = 0;
        rst_b = 1'b0;
        avm_address = 8'h00;
        avm_read = 1'b0;
        avm_write = 1'b0;
        avm_writedata = 32'h00000000;
        avm_byteenable = 4'h0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        // Reset values, unmapped place, disabled byte lane
        for (int i = 0; i < 7; i++) begin
            rdchk(i[5:0], 8'h00, "reset value");
        end
        wr(6'h06, 8'h5A);
        rdchk(6'h06, 8'h00, "unmapped");
        bus_xfer(1'b1, ebt_pkg::IDX_LOW_HOLD, 8'h77, 1'b0);
        rdchk(ebt_pkg::IDX_LOW_HOLD, 8'h00, "lane disabled");
        wr(ebt_pkg::IDX_HIGH_HOLD, 8'hA5);
        wr(ebt_pkg::IDX_LOW_HOLD, 8'h5A);
        rdchk(ebt_pkg::IDX_HIGH_HOLD, 8'hA5, "high hold");
        rdchk(ebt_pkg::IDX_LOW_HOLD, 8'h5A, "low hold");
        // Modulo-N period for every clock select code
        wr(ebt_pkg::IDX_LOW_HOLD, 8'h04);
        wr(ebt_pkg::IDX_HIGH_HOLD, 8'h04);
        for (int c = 0; c < 4; c++) begin
            wr(ebt_pkg::IDX_CONTROL, 8'h20);
            wr(ebt_pkg::IDX_CONTROL, 8'h82 | {3'h0, c[1:0], 3'h0});
            wait_irq(200);
            wait_irq(200);
            chk_int("timeout spacing", 4 << c, irq_last - irq_prev);
            rdchk(ebt_pkg::IDX_CONTROL, 8'hA2 | {3'h0, c[1:0], 3'h0}, "timeout flag");
        end
        wr(ebt_pkg::IDX_CONTROL, 8'h02);
        idle(4);
        base = irq_count;
        idle(100);
        chk_int("irq while stopped", base, irq_count);
        rdchk(ebt_pkg::IDX_CONTROL, 8'h22, "flag after write 0");
        wr(ebt_pkg::IDX_CONTROL, 8'h22);
        rdchk(ebt_pkg::IDX_CONTROL, 8'h02, "flag after write 1");
        // Single pass stops at terminal count
        wr(ebt_pkg::IDX_LOW_HOLD, 8'h03);
        wr(ebt_pkg::IDX_CONTROL, 8'hC2);
        wait_irq(50);
        idle(4);
        base = irq_count;
        rdchk(ebt_pkg::IDX_CONTROL, 8'h62, "single pass");
        idle(60);
        chk_int("irq after single pass", base, irq_count);
        wr(ebt_pkg::IDX_CONTROL, 8'h20);
        // Transmit outputs: route bit and combine functions
        u_ebt_pin_model.set_pin(3, 1'b1);
        u_ebt_pin_model.set_pin(4, 1'b1);
        wr(ebt_pkg::IDX_LOW_HOLD, 8'hFF);
        wr(ebt_pkg::IDX_HIGH_HOLD, 8'hFF);
        wr(ebt_pkg::IDX_CONTROL, 8'h98);
        idle(2);
        chk8("timer pin port", 8'h01, {7'h00, timer_pin});
        chk8("shared pin port", 8'h01, {7'h00, shared_pin});
        wr(ebt_pkg::IDX_CONTROL, 8'h99);
        idle(2);
        chk8("timer pin routed", 8'h00, {7'h00, timer_pin});
        for (int fn = 0; fn < 4; fn++) begin
            for (int s = 0; s < 2; s++) begin
                u_ebt_pin_model.set_pin(2, s[0]);
                wr(ebt_pkg::IDX_SHARED, 8'h40 | {2'h0, fn[1:0], 4'h0});
                idle(1);
                chk8("shared pin combine", {7'h00, fn_out(fn, 1'b0, s[0])}, {7'h00, shared_pin});
            end
        end
        wr(ebt_pkg::IDX_CONTROL, 8'h20);
        // Demodulation, pin a, both edges, fixed gap between edges
        wr(ebt_pkg::IDX_SHARED, 8'hA0);
        wr(ebt_pkg::IDX_CONTROL, 8'h84);
        idle(4);
        base = irq_count;
        u_ebt_pin_model.set_pin(0, 1'b1);
        idle(39);
        u_ebt_pin_model.set_pin(0, 1'b0);
        idle(39);
        u_ebt_pin_model.set_pin(0, 1'b1);
        idle(12);
        chk_int("capture irqs", base + 3, irq_count);
        rdchk(ebt_pkg::IDX_SHARED, 8'hA3, "edge flags");
        bus_xfer(1'b0, ebt_pkg::IDX_LOW_CAPT, 8'h00, 1'b1);
        chk_rng("low slot", 8'hD5, 8'hD9, rd);
        bus_xfer(1'b0, ebt_pkg::IDX_HIGH_CAPT, 8'h00, 1'b1);
        chk_rng("high slot", 8'hD5, 8'hD9, rd);
        wr(ebt_pkg::IDX_SHARED, 8'hA3);
        rdchk(ebt_pkg::IDX_SHARED, 8'hA0, "flags cleared");
        // Pin b selected, every edge code; pin a must be ignored
        for (int code = 0; code < 4; code++) begin
            wr(ebt_pkg::IDX_SHARED, 8'hC3 | {2'h0, code[1:0], 4'h0});
            base = irq_count;
            u_ebt_pin_model.set_pin(0, 1'b0);
            u_ebt_pin_model.set_pin(1, 1'b1);
            idle(12);
            u_ebt_pin_model.set_pin(0, 1'b1);
            u_ebt_pin_model.set_pin(1, 1'b0);
            idle(12);
            t = (code == 0) ? 1 : (code == 1) ? 2 : (code == 2) ? 3 : 0;
            rdchk(ebt_pkg::IDX_SHARED, 8'hC0 | {2'h0, code[1:0], 4'h0} | t[7:0], "edge code");
            chk_int("edge code irqs", base + t[0] + t[1], irq_count);
        end
        // Capture interrupt masked
        wr(ebt_pkg::IDX_CONTROL, 8'h80);
        wr(ebt_pkg::IDX_SHARED, 8'hE3);
        base = irq_count;
        u_ebt_pin_model.set_pin(1, 1'b1);
        idle(12);
        u_ebt_pin_model.set_pin(1, 1'b0);
        idle(12);
        rdchk(ebt_pkg::IDX_SHARED, 8'hE3, "flags masked");
        chk_int("masked irqs", base, irq_count);
        // Demodulation timeout wraps through FF
        wr(ebt_pkg::IDX_CONTROL, 8'hA2);
        wait_irq(300);
        wait_irq(300);
        chk_int("demod wrap spacing", 256, irq_last - irq_prev);
        rdchk(ebt_pkg::IDX_CONTROL, 8'hA2, "demod timeout flag");
        end_sim();
    end
endmodule : tb_eight_bit_timer_demod
`default_nettype wire
